// ==== verilog/accel_monitor_pkg.sv ====
// Shared constants for the accelerometer timing and status monitor
package accel_monitor_pkg;
    // Clock and link timing
    localparam int CLK_HZ = 40_000_000;
    localparam int LINK_BPS = 20_000;
    localparam int BIT_CYCLES = CLK_HZ / LINK_BPS;
    localparam int SAMPLE_PERIOD_US = 10_000;
    localparam int SAMPLE_PERIOD_CYCLES = SAMPLE_PERIOD_US * (CLK_HZ / 1_000_000);
    localparam int SAMPLE_TOL_US = 250;
    localparam int SAMPLE_TOL_CYCLES = SAMPLE_TOL_US * (CLK_HZ / 1_000_000);
    localparam int PPS_TIMEOUT_MS = 1_500;
    localparam int PPS_TIMEOUT_CYCLES = PPS_TIMEOUT_MS * (CLK_HZ / 1_000);
    localparam int SECONDS_PER_WEEK = 604_800;

    // Sample layout: three 16-bit axes, Z first, sent big endian
    localparam int AXIS_BITS = 16;
    localparam int SAMPLE_BITS = 3 * AXIS_BITS;
    localparam int SAMPLE_BYTES = 6;
    localparam int FIFO_DEPTH = 16;

    // Command frame: opcode then 24 bits of time of day
    localparam logic [7:0] CMD_TIME_OP = 8'h54;
    localparam logic [1:0] CMD_LAST_BYTE = 2'h3;

    // Register byte offsets
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_WEEK = 5'h04;
    localparam logic [4:0] REG_SOW = 5'h08;
    localparam logic [4:0] REG_STATUS = 5'h0c;
    localparam logic [4:0] REG_BUF_CNT = 5'h10;
    localparam logic [4:0] REG_SENT_CNT = 5'h14;
    localparam logic [4:0] REG_SAMPLE_ZN = 5'h18;
    localparam logic [4:0] REG_SAMPLE_EW = 5'h1c;

    // Control bit positions
    localparam int CTRL_ERASE_BIT = 0;
    localparam int CTRL_ZERO_BIT = 1;
    localparam int CTRL_ACQ_BIT = 2;

    // Status bit positions
    localparam int ST_PPS_BIT = 0;
    localparam int ST_WEEK_SET_BIT = 1;
    localparam int ST_TFAULT_BIT = 2;
    localparam int ST_AVAIL_BIT = 3;
    localparam int ST_FERR_BIT = 4;
    localparam int ST_OVF_BIT = 5;

    // Reset values
    localparam logic ACQ_EN_RESET = 1'b1;
    localparam logic [15:0] WEEK_RESET = 16'h0000;

    // Serial engine states, Gray coded along the frame
    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_START = 2'b01,
        SER_DATA = 2'b11,
        SER_STOP = 2'b10
    } ser_e;
endpackage

// ==== verilog/sample_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_N,
    // Write side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // Read side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
    } fifo_s;

    fifo_s s;
    fifo_s next_s;
    logic full;
    logic empty;

    // Extra pointer bit tells full from empty without a counter
    assign empty = (s.wr_ptr == s.rd_ptr);
    assign full = (s.wr_ptr[AW] != s.rd_ptr[AW]) && (s.wr_ptr[AW-1:0] == s.rd_ptr[AW-1:0]);
    assign o_in_ready = !full;
    assign o_out_valid = !empty;
    assign o_out_data = s.mem[s.rd_ptr[AW-1:0]];

    // Pointer and storage update
    always_comb begin
        next_s = s;
        if (i_in_valid && !full) begin
            next_s.mem[s.wr_ptr[AW-1:0]] = i_in_data;
            next_s.wr_ptr = s.wr_ptr + (AW+1)'(1);
        end
        if (i_out_ready && !empty) begin
            next_s.rd_ptr = s.rd_ptr + (AW+1)'(1);
        end
    end

    // State register
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/accel_timing_status_monitor.sv ====
// Timing, status and sensor link logic of the station module
//
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module accel_timing_status_monitor
    import accel_monitor_pkg::*;
#(
    parameter int SLOT_CYCLES = SAMPLE_PERIOD_CYCLES,
    parameter int TOL_CYCLES = SAMPLE_TOL_CYCLES,
    parameter int PPS_LOSS_CYCLES = PPS_TIMEOUT_CYCLES
) (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_N,
    // Avalon-MM register slave
    input wire logic [4:0] i_AVM_ADDRESS,
    input wire logic i_AVM_READ,
    input wire logic i_AVM_WRITE,
    input wire logic [31:0] i_AVM_WRITEDATA,
    input wire logic [3:0] i_AVM_BYTEENABLE,
    output logic [31:0] o_AVM_READDATA,
    output logic o_AVM_WAITREQUEST,
    // GNSS receiver side
    input wire logic i_PPS,
    input wire logic i_SOW_VALID,
    input wire logic [19:0] i_SOW,
    input wire logic i_GNSS_LOCK,
    input wire logic i_GNSS_RATE_OK,
    // Network client events
    input wire logic i_CLIENT_UP,
    input wire logic i_PKT_STORE,
    input wire logic i_PKT_SENT,
    // First sensor port link
    output logic o_CMD_TXD,
    input wire logic i_DATA_RXD,
    output logic o_SENSOR_PPS,
    // Status
    output logic o_PPS_PRESENT
);
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [15:0] week;
        logic week_set;
        logic [19:0] sow;
        logic pps_d;
        logic pps_present;
        logic [31:0] pps_timer;
        logic acq_en;
        logic [31:0] buf_cnt;
        logic [31:0] sent_cnt;
        logic tfault;
        logic ferr;
        logic ovf;
        logic [31:0] slot_cnt;
        ser_e tx_st;
        logic [10:0] tx_cnt;
        logic [2:0] tx_bit;
        logic [1:0] tx_byte;
        logic [7:0] tx_sh;
        logic tx_line;
        logic pps_out;
        ser_e rx_st;
        logic [10:0] rx_cnt;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic [2:0] rx_byte;
        logic [SAMPLE_BITS-1:0] smp;
        logic push;
    } mon_s;

    localparam logic [10:0] BIT_LAST = 11'(BIT_CYCLES - 1);
    localparam logic [10:0] BIT_HALF = 11'(BIT_CYCLES / 2 - 1);

    mon_s s;
    mon_s next_s;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [SAMPLE_BITS-1:0] fifo_out_data;
    logic fifo_pop;
    logic req;

    // Address match helper used by read, write and pop decoding
    function automatic logic reg_hit(input logic [4:0] addr, input logic [4:0] off);
        reg_hit = (addr[4:2] == off[4:2]);
    endfunction

    // Byte merge for partial writes
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // One wait state on every access; the ack cycle completes it
    assign req = i_AVM_READ || i_AVM_WRITE;
    assign o_AVM_WAITREQUEST = req && !s.ack;
    assign o_AVM_READDATA = s.rdata;
    assign o_CMD_TXD = s.tx_line;
    assign o_SENSOR_PPS = s.pps_out;
    assign o_PPS_PRESENT = s.pps_present;
    // Reading the east-west word consumes the oldest sample
    assign fifo_pop = s.ack && i_AVM_READ && reg_hit(i_AVM_ADDRESS, REG_SAMPLE_EW);

    // Next state of the whole block
    always_comb begin
        logic pps_rise;
        logic wr_now;
        logic erase;
        logic zero;
        logic rx_mid;
        pps_rise = i_PPS && !s.pps_d;
        wr_now = s.ack && i_AVM_WRITE;
        erase = 1'b0;
        zero = 1'b0;
        rx_mid = 1'b0;
        next_s = s;
        next_s.push = 1'b0;
        // Bus handshake: data is captured when the request is first seen
        next_s.ack = req && !s.ack;
        if (req && !s.ack && i_AVM_READ) begin
            next_s.rdata = 32'h0000_0000;
            if (reg_hit(i_AVM_ADDRESS, REG_CTRL)) begin
                next_s.rdata[CTRL_ACQ_BIT] = s.acq_en;
            end
            if (reg_hit(i_AVM_ADDRESS, REG_WEEK)) begin
                next_s.rdata = {16'h0000, s.week};
            end
            if (reg_hit(i_AVM_ADDRESS, REG_SOW)) begin
                next_s.rdata = {12'h000, s.sow};
            end
            if (reg_hit(i_AVM_ADDRESS, REG_STATUS)) begin
                next_s.rdata[ST_PPS_BIT] = s.pps_present;
                next_s.rdata[ST_WEEK_SET_BIT] = s.week_set;
                next_s.rdata[ST_TFAULT_BIT] = s.tfault;
                next_s.rdata[ST_AVAIL_BIT] = fifo_out_valid;
                next_s.rdata[ST_FERR_BIT] = s.ferr;
                next_s.rdata[ST_OVF_BIT] = s.ovf;
            end
            if (reg_hit(i_AVM_ADDRESS, REG_BUF_CNT)) begin
                next_s.rdata = s.buf_cnt;
            end
            if (reg_hit(i_AVM_ADDRESS, REG_SENT_CNT)) begin
                next_s.rdata = s.sent_cnt;
            end
            // Raw counts straight from the sensor, gravity not removed
            if (reg_hit(i_AVM_ADDRESS, REG_SAMPLE_ZN)) begin
                next_s.rdata = fifo_out_data[47:16];
            end
            if (reg_hit(i_AVM_ADDRESS, REG_SAMPLE_EW)) begin
                next_s.rdata = {16'h0000, fifo_out_data[15:0]};
            end
        end
        // Control writes; erase and zero are self-clearing commands
        if (wr_now && reg_hit(i_AVM_ADDRESS, REG_CTRL) && i_AVM_BYTEENABLE[0]) begin
            erase = i_AVM_WRITEDATA[CTRL_ERASE_BIT];
            zero = i_AVM_WRITEDATA[CTRL_ZERO_BIT];
            next_s.acq_en = i_AVM_WRITEDATA[CTRL_ACQ_BIT];
        end
        // Write-one clears of sticky faults; a new fault the same cycle wins below
        if (wr_now && reg_hit(i_AVM_ADDRESS, REG_STATUS) && i_AVM_BYTEENABLE[0]) begin
            if (i_AVM_WRITEDATA[ST_TFAULT_BIT]) next_s.tfault = 1'b0;
            if (i_AVM_WRITEDATA[ST_FERR_BIT]) next_s.ferr = 1'b0;
            if (i_AVM_WRITEDATA[ST_OVF_BIT]) next_s.ovf = 1'b0;
        end
        // Seconds of week only taken with lock and a matching serial rate
        if (i_SOW_VALID && i_GNSS_LOCK && i_GNSS_RATE_OK) begin
            next_s.sow = i_SOW;
            // Week rolls over locally when seconds wrap
            if (s.week_set && (i_SOW < s.sow)) begin
                next_s.week = s.week + 16'h0001;
            end
        end
        // Client supplied week; until then it stays zero
        if (wr_now && reg_hit(i_AVM_ADDRESS, REG_WEEK) && (i_AVM_BYTEENABLE[1:0] != 2'b00)) begin
            next_s.week = merge16(s.week, i_AVM_WRITEDATA, i_AVM_BYTEENABLE);
            next_s.week_set = 1'b1; // Never cleared short of reset
        end
        // Pulse watchdog: present after an edge, absent after a long silence
        next_s.pps_d = i_PPS;
        if (pps_rise) begin
            next_s.pps_timer = 32'h0000_0000;
            next_s.pps_present = 1'b1;
        end else if (s.pps_timer >= 32'(PPS_LOSS_CYCLES - 1)) begin
            next_s.pps_present = 1'b0;
        end else begin
            next_s.pps_timer = s.pps_timer + 32'h0000_0001;
        end
        // Pulse forwarded on its own channel only while usable
        next_s.pps_out = i_PPS && s.pps_present && s.acq_en;
        // Buffered packet count; erase first so a same-cycle store survives
        next_s.buf_cnt = erase ? 32'h0000_0000 : s.buf_cnt;
        if (i_PKT_STORE && !(i_PKT_SENT && next_s.buf_cnt != 32'h0000_0000)) begin
            if (next_s.buf_cnt != 32'hffff_ffff) next_s.buf_cnt = next_s.buf_cnt + 32'h0000_0001;
        end else if (i_PKT_SENT && !i_PKT_STORE && next_s.buf_cnt != 32'h0000_0000) begin
            next_s.buf_cnt = next_s.buf_cnt - 32'h0000_0001; // Saturates at zero
        end
        // Sent count advances only while a client is connected
        next_s.sent_cnt = zero ? 32'h0000_0000 : s.sent_cnt;
        if (i_PKT_SENT && i_CLIENT_UP) begin
            next_s.sent_cnt = next_s.sent_cnt + 32'h0000_0001;
        end
        // Ten millisecond slot phase, realigned on each pulse
        if (pps_rise || s.slot_cnt >= 32'(SLOT_CYCLES - 1)) begin
            next_s.slot_cnt = 32'h0000_0000;
        end else begin
            next_s.slot_cnt = s.slot_cnt + 32'h0000_0001;
        end
        // Command transmitter: time of day frame on each pulse seen while already present and acquiring
        // A full sample buffer holds back the next frame so the sensor pauses
        unique case (s.tx_st)
            SER_IDLE: begin
                next_s.tx_line = 1'b1;
                if (pps_rise && s.pps_present && s.acq_en && fifo_in_ready) begin
                    next_s.tx_st = SER_START;
                    next_s.tx_sh = CMD_TIME_OP;
                    next_s.tx_byte = 2'h0;
                    next_s.tx_cnt = 11'h000;
                end
            end
            SER_START: begin
                next_s.tx_line = 1'b0;
                next_s.tx_cnt = s.tx_cnt + 11'h001;
                if (s.tx_cnt == BIT_LAST) begin
                    next_s.tx_st = SER_DATA;
                    next_s.tx_cnt = 11'h000;
                    next_s.tx_bit = 3'h0;
                end
            end
            SER_DATA: begin
                next_s.tx_line = s.tx_sh[0]; // LSB first, eight bits, no parity
                next_s.tx_cnt = s.tx_cnt + 11'h001;
                if (s.tx_cnt == BIT_LAST) begin
                    next_s.tx_cnt = 11'h000;
                    next_s.tx_sh = {1'b0, s.tx_sh[7:1]};
                    next_s.tx_bit = s.tx_bit + 3'h1;
                    if (s.tx_bit == 3'h7) next_s.tx_st = SER_STOP;
                end
            end
            SER_STOP: begin
                next_s.tx_line = 1'b1; // One stop bit
                next_s.tx_cnt = s.tx_cnt + 11'h001;
                if (s.tx_cnt == BIT_LAST) begin
                    next_s.tx_cnt = 11'h000;
                    if (s.tx_byte == CMD_LAST_BYTE) begin
                        next_s.tx_st = SER_IDLE;
                    end else begin
                        next_s.tx_st = SER_START;
                        next_s.tx_byte = s.tx_byte + 2'h1;
                        // Time of day follows the opcode, high byte first
                        unique case (s.tx_byte)
                            2'h0: next_s.tx_sh = {4'h0, s.sow[19:16]};
                            2'h1: next_s.tx_sh = s.sow[15:8];
                            default: next_s.tx_sh = s.sow[7:0];
                        endcase
                    end
                end
            end
        endcase
        // Data receiver: six byte samples, Z, north-south, east-west
        unique case (s.rx_st)
            SER_IDLE: begin
                if (!i_DATA_RXD) begin
                    next_s.rx_st = SER_START;
                    next_s.rx_cnt = 11'h000;
                    // First byte marks the sample instant; check its slot phase
                    if (s.rx_byte == 3'h0 && s.slot_cnt > 32'(TOL_CYCLES)
                        && s.slot_cnt < 32'(SLOT_CYCLES - TOL_CYCLES)) begin
                        next_s.tfault = 1'b1;
                    end
                end
            end
            SER_START: begin
                next_s.rx_cnt = s.rx_cnt + 11'h001;
                if (s.rx_cnt == BIT_HALF) begin
                    next_s.rx_cnt = 11'h000;
                    next_s.rx_bit = 3'h0;
                    // A glitch shorter than half a bit is not a start bit
                    next_s.rx_st = i_DATA_RXD ? SER_IDLE : SER_DATA;
                end
            end
            SER_DATA: begin
                next_s.rx_cnt = s.rx_cnt + 11'h001;
                rx_mid = (s.rx_cnt == BIT_LAST);
                if (rx_mid) begin
                    next_s.rx_cnt = 11'h000;
                    next_s.rx_sh = {i_DATA_RXD, s.rx_sh[7:1]};
                    next_s.rx_bit = s.rx_bit + 3'h1;
                    if (s.rx_bit == 3'h7) next_s.rx_st = SER_STOP;
                end
            end
            SER_STOP: begin
                next_s.rx_cnt = s.rx_cnt + 11'h001;
                if (s.rx_cnt == BIT_LAST) begin
                    next_s.rx_st = SER_IDLE;
                    if (!i_DATA_RXD) begin
                        next_s.ferr = 1'b1; // Bad stop bit drops the partial sample
                        next_s.rx_byte = 3'h0;
                    end else begin
                        next_s.smp = {s.smp[SAMPLE_BITS-9:0], s.rx_sh};
                        if (s.rx_byte == 3'(SAMPLE_BYTES - 1)) begin
                            next_s.rx_byte = 3'h0;
                            next_s.push = 1'b1;
                        end else begin
                            next_s.rx_byte = s.rx_byte + 3'h1;
                        end
                    end
                end
            end
        endcase
        // A pulse while the receiver is idle restarts byte alignment so a lost byte cannot skew samples
        if (pps_rise && s.rx_st == SER_IDLE) begin
            next_s.rx_byte = 3'h0;
        end
        // Sample arriving into a full buffer is lost and flagged
        if (s.push && !fifo_in_ready) begin
            next_s.ovf = 1'b1;
        end
    end

    // State register
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            s <= '0;
            s.week <= WEEK_RESET;
            s.acq_en <= ACQ_EN_RESET;
            s.tx_line <= 1'b1;
            s.pps_d <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Sample buffer between the sensor link and the register reads
    sample_fifo #(
        .WIDTH(SAMPLE_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .I_CLK(I_CLK),
        .I_RST_N(I_RST_N),
        .i_in_valid(s.push),
        .i_in_data(s.smp),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(fifo_out_valid),
        .o_out_data(fifo_out_data),
        .i_out_ready(fifo_pop)
    );
endmodule
`default_nettype wire

// ==== tb/accel_sensor_model.sv ====
// Behavioural accelerometer at the far end of the sensor link
`timescale 1ns/1ps
`default_nettype none
module accel_sensor_model
    import accel_monitor_pkg::*;
(
    // Clock and link lines
    input wire logic I_CLK,
    input wire logic i_cmd_txd,
    output logic o_data_rxd,
    // Bench control
    input wire logic i_send,
    input wire logic [47:0] i_sample,
    output logic [31:0] o_cmd_word
);
    logic [7:0] rx_byte;
    int count = 0;
    initial begin
        o_data_rxd = 1'b1;
        o_cmd_word = '0;
    end
    // One sample, Z first, 8N1 LSB first; gravity is left in Z
    always @(posedge I_CLK) begin
        if (i_send) begin
            for (int k = 0; k < 60; k++) begin
                o_data_rxd <= (k % 10 == 0) ? 1'b0 :
                    (k % 10 == 9) ? 1'b1 : i_sample[39 - 8 * (k / 10) + k % 10];
                repeat (BIT_CYCLES) @(posedge I_CLK);
            end
        end
    end
    // Mid-bit decode of commands; only the first frame is kept
    always @(negedge i_cmd_txd) begin
        repeat (BIT_CYCLES / 2) @(posedge I_CLK);
        for (int j = 0; j < 8; j++) begin
            repeat (BIT_CYCLES) @(posedge I_CLK);
            rx_byte[j] = i_cmd_txd;
        end
        repeat (BIT_CYCLES) @(posedge I_CLK);
        if (i_cmd_txd === 1'b1 && count < 4) begin
            o_cmd_word = {o_cmd_word[23:0], rx_byte};
        end
        count++;
    end
endmodule
`default_nettype wire

// ==== tb/accel_timing_status_monitor_checker.sv ====
// Port assertions for the timing and status monitor
`timescale 1ns/1ps
`default_nettype none
module accel_timing_status_monitor_checker
    import accel_monitor_pkg::*;
#(
    parameter int PPS_LOSS_CYCLES = 1000
) (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_N,
    // Register bus
    input wire logic i_AVM_READ,
    input wire logic i_AVM_WRITE,
    input wire logic [31:0] o_AVM_READDATA,
    input wire logic o_AVM_WAITREQUEST,
    // Timing and link
    input wire logic i_PPS,
    input wire logic o_CMD_TXD,
    input wire logic o_SENSOR_PPS,
    input wire logic o_PPS_PRESENT
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);
    logic pps_q;
    int low_run;
    int since_rise;
    // Run counters; a low run must be whole bit times, so count it exactly
    always_ff @(posedge I_CLK) begin
        pps_q <= i_PPS;
        low_run <= o_CMD_TXD ? 0 : low_run + 1;
        since_rise <= (i_PPS && !pps_q) ? 0 : since_rise + 1;
    end
    AST_REQ_WAITS: assert property ($rose(i_AVM_READ || i_AVM_WRITE) |-> o_AVM_WAITREQUEST)
        else $error("request not held off in its first cycle");
    AST_ONE_WAIT: assert property (o_AVM_WAITREQUEST |=> !o_AVM_WAITREQUEST)
        else $error("more than one wait state");
    AST_WAIT_REQ: assert property (o_AVM_WAITREQUEST |-> i_AVM_READ || i_AVM_WRITE)
        else $error("wait state without a request");
    AST_RDATA_HOLD: assert property (!i_AVM_READ |=> $stable(o_AVM_READDATA))
        else $error("read data moved without a read");
    AST_SPPS_GATED: assert property (o_SENSOR_PPS |-> $past(i_PPS) && $past(o_PPS_PRESENT))
        else $error("sensor pulse without a present receiver pulse");
    AST_PRESENT_CAUSE: assert property ($rose(o_PPS_PRESENT) |-> $past(i_PPS) || $past(i_PPS, 2))
        else $error("present without a pulse");
    AST_PRESENT_FAST: assert property ($rose(i_PPS) && $past(I_RST_N) |-> ##[1:2] o_PPS_PRESENT)
        else $error("pulse edge not reported as present");
    AST_PRESENT_LOSS: assert property ($fell(o_PPS_PRESENT) |-> since_rise >= PPS_LOSS_CYCLES - 2)
        else $error("absent reported too early");
    AST_BIT_TIME: assert property ($rose(o_CMD_TXD) |-> low_run % BIT_CYCLES == 0)
        else $error("command line low run not whole bits");
    COV_PRESENT: cover property ($rose(o_PPS_PRESENT));
    COV_LOSS: cover property ($fell(o_PPS_PRESENT));
    COV_TX: cover property ($fell(o_CMD_TXD));
endmodule
`default_nettype wire

// ==== tb/accel_timing_status_monitor_tb_top.sv ====
// Self-checking bench for the timing and status monitor
`timescale 1ns/1ps
`default_nettype none
module accel_timing_status_monitor_tb_top
    import accel_monitor_pkg::*;
;
    localparam int SLOT = 4000;
    localparam int LOSS = 25000;
    localparam int PERIOD = 20000;
    localparam logic [47:0] SAMPLE = 48'h3e80_fff3_0012;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] adr = '0;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdata = '0;
    logic [19:0] sow = '0;
    logic pps = 1'b0, pps_on = 1'b0, sow_vld = 1'b0, lock = 1'b0, client = 1'b0;
    logic store = 1'b0, sent = 1'b0, send = 1'b0, rate_ok = 1'b1;
    logic [31:0] rdata, cmd_word;
    logic wait_req, txd, rxd, spps, present;
    int pps_cnt = 0, sp_hits = 0, err_total = 0, comparisons = 0;
    always #12.5 clk = ~clk;
    // Receiver pulse, ten cycles high, phase restarting when switched on; tally of cycles the pulse is passed on
    always @(posedge clk) begin
        pps_cnt <= (!pps_on || pps_cnt == PERIOD - 1) ? 0 : pps_cnt + 1;
        pps <= pps_on && (pps_cnt < 10);
        sp_hits <= sp_hits + int'(spps === 1'b1);
    end
    accel_timing_status_monitor #(.SLOT_CYCLES(SLOT), .TOL_CYCLES(100), .PPS_LOSS_CYCLES(LOSS))
    u_dut (
        .I_CLK(clk), .I_RST_N(rst_n), .i_AVM_ADDRESS(adr), .i_AVM_READ(rd_en),
        .i_AVM_WRITE(wr_en), .i_AVM_WRITEDATA(wdata), .i_AVM_BYTEENABLE(4'hf),
        .o_AVM_READDATA(rdata), .o_AVM_WAITREQUEST(wait_req), .i_PPS(pps),
        .i_SOW_VALID(sow_vld), .i_SOW(sow), .i_GNSS_LOCK(lock), .i_GNSS_RATE_OK(rate_ok),
        .i_CLIENT_UP(client), .i_PKT_STORE(store), .i_PKT_SENT(sent), .o_CMD_TXD(txd),
        .i_DATA_RXD(rxd), .o_SENSOR_PPS(spps), .o_PPS_PRESENT(present)
    );
    accel_sensor_model u_sensor (
        .I_CLK(clk), .i_cmd_txd(txd), .o_data_rxd(rxd), .i_send(send),
        .i_sample(SAMPLE), .o_cmd_word(cmd_word)
    );
    task automatic finish_test();
        $display("comparisons %0d, errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bus cycle: hold everything until waitrequest is sampled low
    task automatic avm(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        adr <= a;
        wdata <= d;
        wr_en <= wr;
        rd_en <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (wait_req !== 1'b0 && n < 20);
        q = rdata;
        err_total += int'(n >= 20);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        avm(1'b0, a, '0, q);
        chk(q & m, e);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        avm(1'b1, a, d, q);
    endtask
    // Single-cycle event pulses on the receiver and client inputs
    task automatic pulse(input logic st, input logic se, input logic sv, input logic [19:0] v);
        store <= st;
        sent <= se;
        sow_vld <= sv;
        sow <= v;
        @(posedge clk);
        store <= 1'b0;
        sent <= 1'b0;
        sow_vld <= 1'b0;
        @(posedge clk);
    endtask
    initial begin
        logic [31:0] q;
        int n;
        n = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk(REG_WEEK, '1, 32'h0);
        rd_chk(REG_STATUS, 32'h3f, 32'h0);
        wr(REG_WEEK, 32'h800);
        rd_chk(REG_STATUS, 32'h2, 32'h2);
        lock <= 1'b1;
        pulse(1'b0, 1'b0, 1'b1, 20'h64);
        rd_chk(REG_SOW, '1, 32'h64);
        lock <= 1'b0;
        pulse(1'b0, 1'b0, 1'b1, 20'hc8);
        rd_chk(REG_SOW, '1, 32'h64);
        {lock, rate_ok} <= 2'b10;
        pulse(1'b0, 1'b0, 1'b1, 20'hc8);
        rd_chk(REG_SOW, '1, 32'h64);
        {lock, rate_ok} <= 2'b11;
        pulse(1'b0, 1'b0, 1'b1, 20'h93a7f);
        pulse(1'b0, 1'b0, 1'b1, 20'h0);
        rd_chk(REG_WEEK, 32'hffff, 32'h801);
        pulse(1'b0, 1'b0, 1'b1, 20'h5a3c1);
        repeat (3) pulse(1'b1, 1'b0, 1'b0, sow);
        rd_chk(REG_BUF_CNT, '1, 32'h3);
        client <= 1'b1;
        pulse(1'b0, 1'b1, 1'b0, sow);
        rd_chk(REG_BUF_CNT, '1, 32'h2);
        client <= 1'b0;
        pulse(1'b0, 1'b1, 1'b0, sow);
        rd_chk(REG_SENT_CNT, '1, 32'h1);
        client <= 1'b1;
        repeat (2) pulse(1'b0, 1'b1, 1'b0, sow);
        rd_chk(REG_BUF_CNT, '1, 32'h0);
        rd_chk(REG_SENT_CNT, '1, 32'h3);
        repeat (2) pulse(1'b1, 1'b0, 1'b0, sow);
        wr(REG_CTRL, 32'h5);
        rd_chk(REG_BUF_CNT, '1, 32'h0);
        wr(REG_CTRL, 32'h6);
        rd_chk(REG_SENT_CNT, '1, 32'h0);
        // Sample launched on a slot boundary; command frame follows the second pulse
        pps_on <= 1'b1;
        do @(posedge clk); while (pps_cnt != 0);
        repeat (SLOT - 2) @(posedge clk);
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        repeat (PERIOD - SLOT + 100) @(posedge clk);
        chk(32'(sp_hits > 0), 32'h1);
        rd_chk(REG_STATUS, 32'h1, 32'h1);
        chk(32'(present), 32'h1);
        // Pulse stops here; absence is due long before the sample has arrived
        pps_on <= 1'b0;
        do begin
            avm(1'b0, REG_STATUS, '0, q);
            n++;
        end while (q[ST_AVAIL_BIT] !== 1'b1 && n < 50000);
        chk(32'(q[ST_AVAIL_BIT]), 32'h1);
        chk(q & 32'h14, 32'h0);
        rd_chk(REG_SAMPLE_ZN, '1, SAMPLE[47:16]);
        rd_chk(REG_SAMPLE_EW, '1, {16'h0, SAMPLE[15:0]});
        chk(cmd_word, {CMD_TIME_OP, 24'h05a3c1});
        rd_chk(REG_STATUS, 32'h1, 32'h0);
        chk(32'(present), 32'h0);
        finish_test();
    end
    // Watchdog, well beyond the expected run of about 125000 cycles
    initial begin
        repeat (170000) @(posedge clk);
        err_total++;
        finish_test();
    end
endmodule
bind accel_timing_status_monitor accel_timing_status_monitor_checker #(
    .PPS_LOSS_CYCLES(PPS_LOSS_CYCLES)
) u_chk (
    .I_CLK, .I_RST_N, .i_AVM_READ, .i_AVM_WRITE, .o_AVM_READDATA, .o_AVM_WAITREQUEST,
    .i_PPS, .o_CMD_TXD, .o_SENSOR_PPS, .o_PPS_PRESENT
);
`default_nettype wire
